// *** dpd_pkg.sv ***
// Package of constants for the dual-port I/O decode and interrupt routing block.
// Behaviour
// - An enabled port answers exactly eight consecutive I/O addresses from its base.
// - Switch positions 1 to 3 pick the base among seven fixed addresses.
// - Switch position 4 enables the port; off means all I/O cycles ignored.
// - Each port's request goes to one selected IRQ line; none selected, no interrupt.
// - Normal mode: the port drives its own IRQ line directly.
// - Shared mode: several ports share one line without contention over a pull-down.
// - Shared mode without any pull-down provider cannot assert an interrupt.
// - Default: port one at 3E8 on IRQ 5, port two at 2E8 on IRQ 10.
// - Decoding compares address bits 15 to 3, rejecting higher aliases.
package dpd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned BLOCK_W   = 3;
  localparam int unsigned IRQ_NUM   = 16;
  localparam int unsigned IRQ_SEL_W = 5;

  // ----------------------------------------------------------------
  // Switch positions
  // ----------------------------------------------------------------
  localparam int unsigned SW_EN_POS = 3;

  // ----------------------------------------------------------------
  // Base addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_3F8 = 16'h03F8;
  localparam logic [15:0] BASE_2F8 = 16'h02F8;
  localparam logic [15:0] BASE_3E8 = 16'h03E8;
  localparam logic [15:0] BASE_2E8 = 16'h02E8;
  localparam logic [15:0] BASE_2A0 = 16'h02A0;
  localparam logic [15:0] BASE_300 = 16'h0300;
  localparam logic [15:0] BASE_328 = 16'h0328;

  // ----------------------------------------------------------------
  // IRQ selection: value 0 means no jumper, 1 to 16 select IRQ 0 to 15
  // ----------------------------------------------------------------
  localparam logic [4:0] IRQ_NONE = 5'h00;
  localparam logic [4:0] IRQ_DEF1 = 5'h06;
  localparam logic [4:0] IRQ_DEF2 = 5'h0B;

  // ----------------------------------------------------------------
  // Factory switch settings (on is 1, position 1 in bit 0)
  // ----------------------------------------------------------------
  localparam logic [3:0] SW_DEF1 = 4'hD;
  localparam logic [3:0] SW_DEF2 = 4'h9;

  // ----------------------------------------------------------------
  // Interrupt modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPD_MODE_NORMAL,
    DPD_MODE_SHARED,
    DPD_MODE_MASTER
  } dpd_mode_t;

endpackage : dpd_pkg

// *** dpd_top.sv ***
// Address decode and interrupt routing for a two-port serial adapter.
`timescale 1ns/1ps
module dpd_top (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [3:0]  port_one_address_switch_i,
  input  wire logic [3:0]  port_two_address_switch_i,
  input  wire logic [4:0]  port_one_irq_select_i,
  input  wire logic [4:0]  port_two_irq_select_i,
  input  wire logic [1:0]  port_one_irq_mode_select_i,
  input  wire logic [1:0]  port_two_irq_mode_select_i,
  input  wire logic [1:0]  port_irq_req_i,
  input  wire logic [15:0] irq_line_i,
  output logic      [1:0]  port_sel_o,
  output logic      [2:0]  port_reg_o,
  output logic      [15:0] irq_o,
  output logic      [15:0] irq_oe_o,
  output logic      [15:0] irq_pull_oe_o,
  output logic      [1:0]  irq_pending_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] base_of(input logic [2:0] sw);
    case (sw)
      3'h7:    base_of = dpd_pkg::BASE_3F8;
      3'h3:    base_of = dpd_pkg::BASE_2F8;
      3'h5:    base_of = dpd_pkg::BASE_3E8;
      3'h1:    base_of = dpd_pkg::BASE_2E8;
      3'h6:    base_of = dpd_pkg::BASE_2A0;
      3'h2:    base_of = dpd_pkg::BASE_300;
      3'h4:    base_of = dpd_pkg::BASE_328;
      default: base_of = dpd_pkg::BASE_3F8;
    endcase
  endfunction : base_of

  function automatic logic hit(input logic [3:0] sw, input logic [15:0] a);
    logic [15:0] base;
    base = base_of(sw[2:0]);
    hit  = sw[dpd_pkg::SW_EN_POS]
           && (a[15:dpd_pkg::BLOCK_W] == base[15:dpd_pkg::BLOCK_W]);
  endfunction : hit

  function automatic logic [15:0] line_of(input logic [4:0] sel, input logic en);
    line_of = 16'h0000;
    if (en && sel != dpd_pkg::IRQ_NONE && sel <= 5'(dpd_pkg::IRQ_NUM))
    begin
      line_of[4'(sel - 5'h01)] = 1'b1;
    end
  endfunction : line_of

  function automatic dpd_pkg::dpd_mode_t dpd_mode_e(input logic [1:0] m);
    dpd_mode_e = dpd_pkg::dpd_mode_t'(m);
  endfunction : dpd_mode_e

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic        strobe;
  logic [1:0]  nxt_port_sel;
  logic [2:0]  nxt_port_reg;
  logic [1:0]  port_sel_ff;
  logic [2:0]  port_reg_ff;

  always_comb
  begin
    strobe       = io_rd_i || io_wr_i;
    nxt_port_sel = 2'h0;
    nxt_port_reg = 3'h0;
    if (strobe && hit(port_one_address_switch_i, io_addr_i))
    begin
      nxt_port_sel[0] = 1'b1;
      nxt_port_reg    = io_addr_i[2:0];
    end
    if (strobe && hit(port_two_address_switch_i, io_addr_i))
    begin
      nxt_port_sel[1] = 1'b1;
      nxt_port_reg    = io_addr_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      port_sel_ff <= 2'h0;
      port_reg_ff <= 3'h0;
    end
    else
    begin
      port_sel_ff <= nxt_port_sel;
      port_reg_ff <= nxt_port_reg;
    end
  end

  // ----------------------------------------------------------------
  // Port interrupt configuration
  // ----------------------------------------------------------------
  logic [1:0]  mode   [2];
  logic [15:0] line   [2];
  logic [1:0]  normal;
  logic [1:0]  shared;
  logic [1:0]  master;

  always_comb
  begin
    mode[0] = port_one_irq_mode_select_i;
    mode[1] = port_two_irq_mode_select_i;
    line[0] = line_of(port_one_irq_select_i, port_one_address_switch_i[dpd_pkg::SW_EN_POS]);
    line[1] = line_of(port_two_irq_select_i, port_two_address_switch_i[dpd_pkg::SW_EN_POS]);
    normal  = 2'h0;
    shared  = 2'h0;
    master  = 2'h0;
    for (int p = 0; p < 2; p++)
    begin
      case (dpd_mode_e(mode[p]))
        dpd_pkg::DPD_MODE_NORMAL:
        begin
          normal[p] = 1'b1;
        end
        dpd_pkg::DPD_MODE_SHARED:
        begin
          shared[p] = 1'b1;
        end
        dpd_pkg::DPD_MODE_MASTER:
        begin
          shared[p] = 1'b1;
          master[p] = 1'b1;
        end
        default:
        begin
          normal[p] = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line drive
  // ----------------------------------------------------------------
  logic [15:0] nxt_irq;
  logic [15:0] nxt_irq_oe;
  logic [15:0] irq_ff;
  logic [15:0] irq_oe_ff;

  always_comb
  begin
    nxt_irq    = 16'h0000;
    nxt_irq_oe = 16'h0000;
    for (int p = 0; p < 2; p++)
    begin
      if (normal[p])
      begin
        nxt_irq_oe = nxt_irq_oe | line[p];
      end
      if ((normal[p] || shared[p]) && port_irq_req_i[p])
      begin
        nxt_irq    = nxt_irq | line[p];
        nxt_irq_oe = nxt_irq_oe | line[p];
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      irq_ff    <= 16'h0000;
      irq_oe_ff <= 16'h0000;
    end
    else
    begin
      irq_ff    <= nxt_irq;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  // ----------------------------------------------------------------
  // Shared pull-down and pending requests
  // ----------------------------------------------------------------
  logic [15:0] nxt_pull_oe;
  logic [1:0]  nxt_pending;
  logic [15:0] pull_oe_ff;
  logic [1:0]  pending_ff;

  always_comb
  begin
    nxt_pull_oe = 16'h0000;
    nxt_pending = 2'h0;
    for (int p = 0; p < 2; p++)
    begin
      if (master[p])
      begin
        nxt_pull_oe = nxt_pull_oe | line[p];
      end
      nxt_pending[p] = (normal[p] || shared[p]) && port_irq_req_i[p]
                       && (line[p] != 16'h0000);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pull_oe_ff <= 16'h0000;
      pending_ff <= 2'h0;
    end
    else
    begin
      pull_oe_ff <= nxt_pull_oe;
      pending_ff <= nxt_pending;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port_sel_o    = port_sel_ff;
  assign port_reg_o    = port_reg_ff;
  assign irq_o         = irq_ff;
  assign irq_oe_o      = irq_oe_ff;
  assign irq_pull_oe_o = pull_oe_ff;
  assign irq_pending_o = pending_ff;

endmodule : dpd_top

// *** dpd_top_asserts.sv ***
// Checker of the decode and interrupt routing outputs.
`timescale 1ns/1ps
module dpd_top_asserts (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_rd_i,
  input wire logic        io_wr_i,
  input wire logic [3:0]  port_one_address_switch_i,
  input wire logic [4:0]  port_one_irq_select_i,
  input wire logic [4:0]  port_two_irq_select_i,
  input wire logic [1:0]  port_one_irq_mode_select_i,
  input wire logic [1:0]  port_two_irq_mode_select_i,
  input wire logic [1:0]  port_irq_req_i,
  input wire logic [1:0]  port_sel_o,
  input wire logic [2:0]  port_reg_o,
  input wire logic [15:0] irq_o,
  input wire logic [15:0] irq_oe_o,
  input wire logic [1:0]  irq_pending_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sel_cause_a: assert property (
    port_sel_o != 2'h0 |-> $past((io_rd_i | io_wr_i) && io_addr_i[15:10] == 6'h00))
    else $error("select without a strobed low address");
  reg_offset_a: assert property (
    port_sel_o != 2'h0 |-> port_reg_o == $past(io_addr_i[2:0]))
    else $error("offset does not follow address");
  disabled_port_a: assert property (
    !port_one_address_switch_i[3] |=> !port_sel_o[0])
    else $error("disabled port selected");
  default_base_a: assert property (
    port_one_address_switch_i == 4'hD && (io_rd_i | io_wr_i) && io_addr_i[15:3] == 13'h007D
    |=> port_sel_o[0])
    else $error("base block not decoded");
  no_line_a: assert property (
    port_one_irq_select_i == 5'h00 && port_two_irq_select_i == 5'h00
    |=> irq_oe_o == 16'h0000 && irq_o == 16'h0000)
    else $error("line driven with no selection");
  normal_drive_a: assert property (
    port_one_irq_mode_select_i == 2'h0 && port_one_address_switch_i[3]
    && port_one_irq_select_i inside {[5'h01:5'h10]}
    |=> irq_oe_o[$past(port_one_irq_select_i) - 5'h01])
    else $error("normal line not driven");
  shared_release_a: assert property (
    port_one_irq_mode_select_i inside {2'h1, 2'h2}
    && port_two_irq_mode_select_i inside {2'h1, 2'h2} && port_irq_req_i == 2'h0
    |=> irq_oe_o == 16'h0000)
    else $error("shared line held while idle");
  pending_cause_a: assert property (
    irq_pending_o[0] |-> $past(port_irq_req_i[0] && port_one_address_switch_i[3]))
    else $error("pending without request");
endmodule : dpd_top_asserts
bind dpd_top dpd_top_asserts u_chk (.core_clk_i, .sys_rst_i, .io_addr_i, .io_rd_i, .io_wr_i,
  .port_one_address_switch_i, .port_one_irq_select_i, .port_two_irq_select_i,
  .port_one_irq_mode_select_i, .port_two_irq_mode_select_i, .port_irq_req_i, .port_sel_o,
  .port_reg_o, .irq_o, .irq_oe_o, .irq_pending_o);

// *** dpd_bus_model.sv ***
// Host model of the sixteen IRQ lines with pull-downs and floating levels.
`timescale 1ns/1ps
module dpd_bus_model (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] irq_i,
  input  wire logic [15:0] irq_oe_i,
  input  wire logic [15:0] irq_pull_oe_i,
  input  wire logic [15:0] ext_pull_i,
  output logic      [15:0] irq_line_o,
  output logic      [15:0] irq_event_o
);
  logic [15:0] dfn;
  logic [15:0] lvl_ff;
  logic [15:0] dfn_ff;
  // An undriven line without pull-down floats and is shown toggling.
  assign dfn = irq_oe_i | irq_pull_oe_i | ext_pull_i;
  assign irq_line_o = (irq_oe_i & irq_i) | (~dfn & ~lvl_ff);
  // The host sees only a rise from a driven or pulled-down low.
  assign irq_event_o = irq_line_o & dfn & ~lvl_ff & dfn_ff;
  always_ff @(posedge core_clk_i)
  begin
    lvl_ff <= irq_line_o;
    dfn_ff <= dfn;
  end
endmodule : dpd_bus_model

// *** dpd_tb.sv ***
// Self-checking testbench of the decode and interrupt routing block.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("Error %s exp %h got %h", n, e, g); \
    end \
  end
module testbench;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  sw [2];
  logic [4:0]  sel [2];
  logic [1:0]  mode [2];
  logic [1:0]  req = 2'h0;
  logic [15:0] ext = 16'h0000;
  logic [15:0] line, evt, irq, oe, pull, e_irq, e_oe, e_pull;
  logic [1:0]  psel, pend, e_sel, e_pend;
  logic [2:0]  preg;
  int          fails = 0;
  int          samples_checked = 0;
  int          nev;
  dpd_top DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(addr), .io_rd_i(rd),
    .io_wr_i(wr), .port_one_address_switch_i(sw[0]), .port_two_address_switch_i(sw[1]),
    .port_one_irq_select_i(sel[0]), .port_two_irq_select_i(sel[1]),
    .port_one_irq_mode_select_i(mode[0]), .port_two_irq_mode_select_i(mode[1]),
    .port_irq_req_i(req), .irq_line_i(line), .port_sel_o(psel), .port_reg_o(preg),
    .irq_o(irq), .irq_oe_o(oe), .irq_pull_oe_o(pull), .irq_pending_o(pend));
  dpd_bus_model u_bus (.core_clk_i(core_clk_i), .irq_i(irq), .irq_oe_i(oe),
    .irq_pull_oe_i(pull), .ext_pull_i(ext), .irq_line_o(line), .irq_event_o(evt));
  initial forever #25 core_clk_i = ~core_clk_i;
  function automatic int base(input logic [2:0] s);
    int t [8] = '{0, 'h2E8, 'h300, 'h2F8, 'h328, 'h3E8, 'h2A0, 'h3F8};
    return t[s];
  endfunction : base
  // One cycle: predict from the held inputs, then compare after the edge.
  task automatic cyc();
    e_sel  = 2'h0;
    e_pend = 2'h0;
    e_oe   = 16'h0000;
    e_irq  = 16'h0000;
    e_pull = 16'h0000;
    for (int p = 0; p < 2; p++)
    begin
      if (sw[p][3] && (rd || wr) && addr[15:3] == base(sw[p][2:0]) >> 3)
        e_sel[p] = 1'b1;
      if (sw[p][3] && sel[p] != 5'h00 && mode[p] != 2'h3)
      begin
        e_pend[p] = req[p];
        e_irq[sel[p] - 1] |= req[p];
        e_oe[sel[p] - 1] |= (mode[p] == 2'h0) || req[p];
        e_pull[sel[p] - 1] |= (mode[p] == 2'h2);
      end
    end
    @(negedge core_clk_i);
    `CHK("sel", e_sel, psel)
    if (e_sel != 2'h0)
      `CHK("reg", addr[2:0], preg)
    `CHK("oe", e_oe, oe)
    `CHK("irq", e_irq, irq)
    `CHK("pull", e_pull, pull)
    `CHK("pend", e_pend, pend)
  endtask : cyc
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial
  begin
    sw = '{dpd_pkg::SW_DEF1, dpd_pkg::SW_DEF2};
    sel = '{dpd_pkg::IRQ_DEF1, dpd_pkg::IRQ_DEF2};
    mode = '{2'h0, 2'h0};
    void'($urandom(32'h8B35));
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 600; i++)
    begin
      for (int p = 0; p < 2 && i >= 40; p++)
      begin
        sw[p] = {1'($urandom % 4 != 0), 3'(1 + $urandom % 7)};
        sel[p] = 5'($urandom % 17);
        mode[p] = 2'($urandom);
      end
      if (i % 64 == 63)
        sel = '{5'h00, 5'h00};
      addr = 16'(base(sw[$urandom % 2][2:0]) + $urandom % 10 - 1);
      if ($urandom % 4 == 0)
        addr[10 + $urandom % 6] = 1'b1;
      rd = 1'($urandom);
      wr = !rd && 1'($urandom);
      req = 2'($urandom);
      ext = 16'($urandom);
      cyc();
    end
    for (int k = 0; k < 3; k++)
    begin
      sw = '{4'hD, 4'h9};
      sel = '{5'h06, 5'h06};
      mode = '{2'h1, (k == 2) ? 2'h2 : 2'h1};
      ext = (k == 1) ? 16'h0020 : 16'h0000;
      nev = 0;
      for (int j = 0; j < 16; j++)
      begin
        req = {1'b0, 1'(j >> 1)};
        cyc();
        nev += (evt[5] === 1'b1);
      end
      `CHK("events", (k == 0) ? 0 : 4, nev)
    end
    summarize();
  end
endmodule : testbench
